// ---- output_compare_timebase_sync.sv ----
// Overview of operation
// [RULE_01] 16-bit counter counts up, wraps to zero
// [RULE_02] Event when counter matches either compare value
// [RULE_03] Synchronous mode runs as soon as clocked
// [RULE_04] Synchronous mode: sync event clears counter
// [RULE_05] Trigger mode: hold counter until sync event
// [RULE_06] Select field resets zero; zero is free-run
// [RULE_07] Nonzero select enables sync, chooses source
// [RULE_08] Bit 7 set selects trigger, clear synchronous
// [RULE_09] Uncascaded modules use independent 16-bit timers
// [RULE_10] Odd low half, next even high half
// [RULE_11] Odd rollover increments paired even counter
// [RULE_12] Cascade only when bit 8 set in both
// [RULE_13] Primary and secondary compare values both matched
// [RULE_14] Counter advances one per selected clock edge
module output_compare_timebase_sync
#(
   // Number of compare modules; pairs need an even count
   parameter int unsigned MODULES = oc_timebase_pkg::NUM_MODULES
)(
   // Clock and asynchronous reset
   input  wire logic                                               CLK,
   input  wire logic                                               RST,
   // One strobe per module for each edge of its clock source
   input  wire logic [MODULES-1:0]                                 CLK_SOURCE_TICK,
   // Second control word per module: select, trigger, cascade
   input  wire logic [MODULES-1:0][oc_timebase_pkg::CTRL_W-1:0]    COMPARE_CONTROL_SECOND,
   // Compare values per module
   input  wire logic [MODULES-1:0][oc_timebase_pkg::CNT_W-1:0]     PRIMARY_COMPARE_VALUE,
   input  wire logic [MODULES-1:0][oc_timebase_pkg::CNT_W-1:0]     SECONDARY_COMPARE_VALUE,
   // Sync and trigger events, indexed by the select value
   input  wire logic [(1<<oc_timebase_pkg::SEL_W)-1:0]             SYNC_SOURCES,
   // Counters, match flags and cascade state
   output logic [MODULES-1:0][oc_timebase_pkg::CNT_W-1:0]          COMPARE_TIMEBASE_COUNTER,
   output logic [MODULES-1:0]                                      PRIMARY_MATCH,
   output logic [MODULES-1:0]                                      SECONDARY_MATCH,
   output logic [MODULES-1:0]                                      CASCADED
);
   import oc_timebase_pkg::*;

   // Module index 0 is the odd-numbered module of a pair, index 1 its
   // even-numbered partner. Cascaded, index 0 holds the low 16 bits and
   // index 1 the high 16 bits of one 32-bit counter.
   //
   // Counters change at the clock edge that samples a tick; match flags
   // follow one cycle later, so a match is seen for as long as the
   // counter stays on the compared value.
   //
   // Both control words of a pair should be set to the same mode: the
   // high half ignores its own select and trigger bits while cascaded
   // and follows the clear and run of the low half instead.
   //
   // A unit in trigger mode stays running after its event until the
   // mode changes; leaving trigger mode or selecting zero re-arms it.
   //
   // Select value zero is free running; source index zero is never read.

   // Pairs need a nonzero even module count; refused at elaboration
   if (MODULES == 0 || (MODULES % 2) != 0) begin : g_bad_count
      $error("MODULES must be a nonzero even number");
   end

   // Registered match flags, one bit per module
   typedef struct packed {
      logic [MODULES-1:0] pmatch;   // Primary compare matched
      logic [MODULES-1:0] smatch;   // Secondary compare matched
   } top_state_t;

   top_state_t                     state_ff;    // Match flag register
   top_state_t                     nxt_state;   // Next match flags

   // Per-module signals between units and the compare logic
   logic [MODULES-1:0]             run;         // Unit may count
   logic [MODULES-1:0]             clr;         // Unit clears this cycle
   logic [MODULES-1:0]             wrap;        // Unit rolls over this cycle
   logic [MODULES-1:0][CNT_W-1:0]  cnt;         // Unit counter values
   logic [MODULES-1:0]             pair_on;     // Pair cascaded
   logic [MODULES-1:0]             evt;         // Chosen sync event per unit

   // Wide views of each module's pair, used when cascaded
   logic [MODULES-1:0][WIDE_W-1:0] wide_cnt;    // Pair counter, high:low
   logic [MODULES-1:0][WIDE_W-1:0] wide_pri;    // Pair primary value
   logic [MODULES-1:0][WIDE_W-1:0] wide_sec;    // Pair secondary value

   // The high half takes its step from the low half's rollover, and its
   // clear and run from the low half too, so that a sync clear or a
   // trigger hold acts on all 32 bits at once. The low half takes nothing
   // from its mate; that keeps the carry path free of a loop.
   // Index g runs over modules; LO is the low index of g's pair.
   // Each module is one timebase unit.
   genvar g;
   generate
      for (g = 0; g < MODULES; g++) begin : g_mod
         // Partner index and low index of the pair
         localparam int unsigned MATE   = g ^ 1;
         localparam int unsigned LO     = g - (g % 2);
         // Even index is the odd-numbered (low) module
         localparam bit          IS_LOW = ((g % 2) == 0);
         logic [SEL_W-1:0] sel;        // Sync source select field
         logic             is_high;    // Acting as high half
         logic             mate_wrap;  // Carry from the low half
         logic             mate_clr;   // Clear from the low half
         logic             mate_run;   // Run permission from the low half

         // Sync source select field of this module
         assign sel = COMPARE_CONTROL_SECOND[g][POS_SEL_LO +: SEL_W];
         // Cascade needs the enable bit in both modules of the pair
         assign pair_on[g] = COMPARE_CONTROL_SECOND[g][POS_CASCADE]
                          && COMPARE_CONTROL_SECOND[MATE][POS_CASCADE]; // RULE_12
         // Only the even-numbered (high) module of a pair follows its mate
         assign is_high = pair_on[g] && !IS_LOW;                          // RULE_10
         // Nonzero select picks one source
         assign evt[g] = SYNC_SOURCES[sel];                              // RULE_07

         // Low half takes nothing from its mate
         if (IS_LOW) begin : g_low
            assign mate_wrap = 1'b0;
            assign mate_clr  = 1'b0;
            assign mate_run  = 1'b0;
         end else begin : g_high
            assign mate_wrap = wrap[MATE];                               // RULE_11
            assign mate_clr  = clr[MATE];
            assign mate_run  = run[MATE];
         end

         // Wide pair views; both modules of a pair see the same values
         assign wide_cnt[g] = {cnt[LO+1], cnt[LO]};                      // RULE_10
         assign wide_pri[g] = {PRIMARY_COMPARE_VALUE[LO+1], PRIMARY_COMPARE_VALUE[LO]};
         assign wide_sec[g] = {SECONDARY_COMPARE_VALUE[LO+1], SECONDARY_COMPARE_VALUE[LO]};

         // Counter, mode decode and trigger state of one module.
         // Uncascaded, the unit counts its own ticks; as high half it
         // counts the low half's rollovers instead.
         oc_timebase_unit u_unit (
            .clk       (CLK),
            .rst       (RST),
            .tick      (CLK_SOURCE_TICK[g]),
            .sel       (sel),
            .trig_mode (COMPARE_CONTROL_SECOND[g][POS_TRIG]),             // RULE_08
            .sync_evt  (evt[g]),
            .use_carry (is_high),                                         // RULE_09
            .carry_in  (mate_wrap),                                       // RULE_11
            .ext_clear (mate_clr),
            .ext_run   (mate_run),
            .run       (run[g]),
            .clear     (clr[g]),
            .wrap      (wrap[g]),
            .count     (cnt[g])
         );
      end
   endgenerate

   // Match flags are registered so that they stand a full cycle after
   // the counter reaches the value. In a cascaded pair both modules
   // compare the full 32 bits and so raise their flags together; the
   // low half alone reaching its own value does not count.
   // Compare against both values, 16 bits alone or 32 bits cascaded
   always_comb begin
      nxt_state = state_ff;
      for (int m = 0; m < MODULES; m++) begin
         if (pair_on[m]) begin
            // Cascaded: both modules report the wide match
            nxt_state.pmatch[m] = (wide_cnt[m] == wide_pri[m]);            // RULE_02
            nxt_state.smatch[m] = (wide_cnt[m] == wide_sec[m]);            // RULE_13
         end else begin
            // Independent: each module matches its own counter
            nxt_state.pmatch[m] = (cnt[m] == PRIMARY_COMPARE_VALUE[m]);    // RULE_02
            nxt_state.smatch[m] = (cnt[m] == SECONDARY_COMPARE_VALUE[m]);  // RULE_13
         end
      end
   end

   // Match flags registered; reset clears them so that no
   // stale match is seen while the counters restart from zero
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outward view of counters, flags and cascade state.
   // Counters come straight from the unit registers.
   assign COMPARE_TIMEBASE_COUNTER = cnt;
   assign PRIMARY_MATCH            = state_ff.pmatch;
   assign SECONDARY_MATCH          = state_ff.smatch;
   assign CASCADED                 = pair_on;

   // Checks below watch module pair zero. Each is clocked on the block
   // clock and idle while reset is high. Counter checks look at the
   // counter one cycle after the cause; flag checks allow the one-cycle
   // register delay of the match flags.

   // Low half of pair zero rolls over without a clear
   sequence s_low_rollover;
      pair_on[1] && wrap[0] && !clr[0];
   endsequence
   // High half then shows one more than before
   sequence s_high_stepped;
      cnt[1] == $past(cnt[1]) + CNT_ONE;
   endsequence

   // Independent primary match raises its flag a cycle later
   chk_primary_match: assert property (@(posedge CLK) disable iff (RST)
      (!pair_on[0] && cnt[0] == PRIMARY_COMPARE_VALUE[0]) |=> PRIMARY_MATCH[0]) // RULE_02
      else $error("primary match missed");

   // Independent secondary match raises its flag a cycle later
   chk_second_match: assert property (@(posedge CLK) disable iff (RST)
      (!pair_on[0] && cnt[0] == SECONDARY_COMPARE_VALUE[0]) |=> SECONDARY_MATCH[0]) // RULE_13
      else $error("secondary match missed");

   // Free-running counter wraps from the top value to zero
   chk_free_wrap: assert property (@(posedge CLK) disable iff (RST)
      (COMPARE_CONTROL_SECOND[0][POS_SEL_LO +: SEL_W] == SEL_FREE && CLK_SOURCE_TICK[0]
       && cnt[0] == CNT_MAX) |=> (cnt[0] == CNT_ZERO)) // RULE_01
      else $error("counter did not wrap to zero");

   // Select zero always lets the counter run
   chk_free_run: assert property (@(posedge CLK) disable iff (RST)
      (COMPARE_CONTROL_SECOND[0][POS_SEL_LO +: SEL_W] == SEL_FREE) |-> run[0]) // RULE_06
      else $error("free-running module stopped");

   // Synchronous mode runs without waiting for an event
   chk_sync_runs: assert property (@(posedge CLK) disable iff (RST)
      (!pair_on[0] && COMPARE_CONTROL_SECOND[0][POS_SEL_LO +: SEL_W] != SEL_FREE
       && !COMPARE_CONTROL_SECOND[0][POS_TRIG]) |-> run[0]) // RULE_03
      else $error("synchronous module not running");

   // Low rollover steps the high half
   chk_cascade_carry: assert property (@(posedge CLK) disable iff (RST)
      s_low_rollover |=> s_high_stepped) // RULE_11
      else $error("high half did not take carry");

   // One enable alone never cascades
   chk_no_cascade: assert property (@(posedge CLK) disable iff (RST)
      (!COMPARE_CONTROL_SECOND[0][POS_CASCADE]) |-> !pair_on[1]) // RULE_12
      else $error("cascade with one enable");

   // Wide primary match raises both flags of the pair
   chk_pair_primary: assert property (@(posedge CLK) disable iff (RST)
      (pair_on[0] && wide_cnt[0] == wide_pri[0])
      |=> (PRIMARY_MATCH[0] && PRIMARY_MATCH[1])) // RULE_10
      else $error("wide primary match missed");

   // Wide secondary match raises both flags of the pair
   chk_pair_second: assert property (@(posedge CLK) disable iff (RST)
      (pair_on[0] && wide_cnt[0] == wide_sec[0])
      |=> (SECONDARY_MATCH[0] && SECONDARY_MATCH[1])) // RULE_13
      else $error("wide secondary match missed");

   // A clear of the low half clears the high half too
   chk_pair_clear: assert property (@(posedge CLK) disable iff (RST)
      (pair_on[1] && clr[0]) |=> (cnt[1] == CNT_ZERO)) // RULE_04
      else $error("high half not cleared with low half");

   // Without a tick a free-running counter holds
   chk_free_hold: assert property (@(posedge CLK) disable iff (RST)
      (COMPARE_CONTROL_SECOND[0][POS_SEL_LO +: SEL_W] == SEL_FREE && !CLK_SOURCE_TICK[0])
      |=> (cnt[0] == $past(cnt[0]))) // RULE_14
      else $error("counter moved without a tick");

   // Uncascaded high module counts its own ticks
   chk_indep_high: assert property (@(posedge CLK) disable iff (RST)
      (!pair_on[1] && COMPARE_CONTROL_SECOND[1][POS_SEL_LO +: SEL_W] == SEL_FREE
       && CLK_SOURCE_TICK[1]) |=> (cnt[1] == $past(cnt[1]) + CNT_ONE)) // RULE_09
      else $error("independent module did not count");

   // Both enables set cascade both modules
   chk_both_enable: assert property (@(posedge CLK) disable iff (RST)
      (COMPARE_CONTROL_SECOND[0][POS_CASCADE] && COMPARE_CONTROL_SECOND[1][POS_CASCADE])
      |-> (CASCADED[0] && CASCADED[1])) // RULE_12
      else $error("pair not cascaded with both enables");

   // Primary flag drops once the counter leaves the value
   chk_match_drop: assert property (@(posedge CLK) disable iff (RST)
      (!pair_on[0] && cnt[0] != PRIMARY_COMPARE_VALUE[0]) |=> !PRIMARY_MATCH[0]) // RULE_02
      else $error("primary flag without a match");

   // Secondary flag drops once the counter leaves the value
   chk_sec_drop: assert property (@(posedge CLK) disable iff (RST)
      (!pair_on[0] && cnt[0] != SECONDARY_COMPARE_VALUE[0]) |=> !SECONDARY_MATCH[0]) // RULE_13
      else $error("secondary flag without a match");

   // Synchronous event clears the counter at the next edge
   chk_sync_clear_top: assert property (@(posedge CLK) disable iff (RST)
      (!pair_on[0] && COMPARE_CONTROL_SECOND[0][POS_SEL_LO +: SEL_W] != SEL_FREE
       && !COMPARE_CONTROL_SECOND[0][POS_TRIG] && evt[0]) |=> (cnt[0] == CNT_ZERO)) // RULE_04
      else $error("sync event ignored");

   // Armed trigger mode holds the counter
   chk_trig_hold_top: assert property (@(posedge CLK) disable iff (RST)
      (!pair_on[0] && COMPARE_CONTROL_SECOND[0][POS_SEL_LO +: SEL_W] != SEL_FREE
       && COMPARE_CONTROL_SECOND[0][POS_TRIG] && !run[0]) |=> (cnt[0] == $past(cnt[0]))) // RULE_05
      else $error("armed counter moved");

   // High half follows the low half's clear and run
   chk_high_follows: assert property (@(posedge CLK) disable iff (RST)
      pair_on[1] |-> (run[1] == run[0] && clr[1] == clr[0])) // RULE_11
      else $error("high half left its low half");

   // High half holds while the low half does not roll over
   chk_no_carry_hold: assert property (@(posedge CLK) disable iff (RST)
      (pair_on[1] && !wrap[0] && !clr[0]) |=> (cnt[1] == $past(cnt[1]))) // RULE_11
      else $error("high half moved without a carry");

   // Low half of a pair wraps to zero on rollover
   chk_low_wraps: assert property (@(posedge CLK) disable iff (RST)
      (pair_on[0] && wrap[0]) |=> (cnt[0] == CNT_ZERO)) // RULE_01
      else $error("low half did not wrap");
endmodule : output_compare_timebase_sync

// ---- oc_timebase_pkg.sv ----
package oc_timebase_pkg;
   // Counter and cascade widths
   localparam int unsigned CNT_W      = 16;
   localparam int unsigned WIDE_W     = 32;
   localparam int unsigned SEL_W      = 5;
   // Default number of compare modules (pairs need an even count)
   localparam int unsigned NUM_MODULES = 2;
   // Sync source select value meaning free-running operation
   localparam logic [SEL_W-1:0] SEL_FREE = 5'h0_0;
   // Second control register field positions
   localparam int unsigned POS_SEL_LO  = 0;
   localparam int unsigned POS_TRIG    = 7;
   localparam int unsigned POS_CASCADE = 8;
   localparam int unsigned CTRL_W      = 16;
   // Counter limits
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
   // Reset value of the second control register
   localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
   // Trigger-mode run state, Gray coded
   typedef enum logic [0:0] {
      ST_ARMED   = 1'b0,
      ST_RUNNING = 1'b1
   } run_state_t;
endpackage : oc_timebase_pkg

// ---- oc_timebase_unit.sv ----
// One 16-bit compare timebase; carry input lets it act as the high half of a pair
module oc_timebase_unit
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 tick,       // Selected clock source edge
   input  wire logic [oc_timebase_pkg::SEL_W-1:0] sel, // Sync source select
   input  wire logic                 trig_mode,  // Trigger mode select
   input  wire logic                 sync_evt,   // Event from chosen source
   input  wire logic                 use_carry,  // Advance on carry, not on tick
   input  wire logic                 carry_in,   // Low half rolled over
   input  wire logic                 ext_clear,  // Pair-wide clear from low half
   input  wire logic                 ext_run,    // Pair-wide run permission
   output logic                      run,        // Counting permitted this cycle
   output logic                      clear,      // Clearing this cycle
   output logic                      wrap,       // Rollover this cycle
   output logic [oc_timebase_pkg::CNT_W-1:0] count   // Current counter value
);
   import oc_timebase_pkg::*;

   // All unit state
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      run_state_t       st;
   } unit_state_t;

   unit_state_t state_ff;
   unit_state_t nxt_state;
   logic        own_run;
   logic        own_clear;
   logic        step;

   // Mode decode and next state
   always_comb begin
      nxt_state = state_ff;
      own_clear = 1'b0;
      own_run   = 1'b1;
      if (sel == SEL_FREE) begin                   // RULE_06
         nxt_state.st = ST_ARMED;
      end else if (!trig_mode) begin               // RULE_07 RULE_08
         own_clear    = sync_evt;                  // RULE_04
         nxt_state.st = ST_ARMED;                  // RULE_03
      end else begin
         unique case (state_ff.st)
            ST_ARMED: begin
               own_run = 1'b0;                     // RULE_05
               if (sync_evt) begin
                  nxt_state.st = ST_RUNNING;
               end
            end
            ST_RUNNING: begin
               own_run = 1'b1;
            end
         endcase
      end
      run   = use_carry ? ext_run : own_run;
      clear = use_carry ? ext_clear : own_clear;
      step  = use_carry ? carry_in : tick;
      wrap  = run && step && (state_ff.cnt == CNT_MAX);
      if (clear) begin
         nxt_state.cnt = CNT_ZERO;
      end else if (run && step) begin
         nxt_state.cnt = state_ff.cnt + CNT_ONE;   // RULE_01 RULE_14
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= '{cnt: CNT_ZERO, st: ST_ARMED};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign count = state_ff.cnt;

   chk_count_step: assert property (@(posedge clk) disable iff (rst)
      (run && step && !clear) |=> (count == $past(count) + CNT_ONE)) // RULE_14
      else $error("counter did not advance by one");
   chk_trig_hold: assert property (@(posedge clk) disable iff (rst)
      (!use_carry && trig_mode && sel != SEL_FREE && state_ff.st == ST_ARMED && !clear)
      |=> (count == $past(count))) // RULE_05
      else $error("counter moved while waiting for trigger");
   chk_sync_clear: assert property (@(posedge clk) disable iff (rst)
      (!use_carry && !trig_mode && sel != SEL_FREE && sync_evt) |=> (count == CNT_ZERO)) // RULE_04
      else $error("sync event did not clear counter");
endmodule : oc_timebase_unit

// ---- tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import oc_timebase_pkg::*;

   logic                          clk = 1'b0;   // Bench clock, 125 MHz
   logic                          rst = 1'b1;   // Async reset, high
   logic [1:0]                    tick = '0;    // Clock source strobes
   logic [1:0][CTRL_W-1:0]        ctrl = '0;    // Second control words
   logic [1:0][CNT_W-1:0]         pri = '0;     // Primary compare values
   logic [1:0][CNT_W-1:0]         sec = '0;     // Secondary compare values
   logic [(1<<SEL_W)-1:0]         sync_src = '0; // Sync event pulses
   logic [1:0][CNT_W-1:0]         cnt;          // Counters
   logic [1:0]                    pmatch;       // Primary match flags
   logic [1:0]                    smatch;       // Secondary match flags
   logic [1:0]                    casc;         // Pair cascaded
   int                            n_errors = 0; // Mismatches
   int                            checked = 0;  // Comparisons made
   int                            cycles = 0;   // Hang guard

   output_compare_timebase_sync #(.MODULES(2)) u_output_compare_timebase_sync (
      .CLK                      (clk),
      .RST                      (rst),
      .CLK_SOURCE_TICK          (tick),
      .COMPARE_CONTROL_SECOND   (ctrl),
      .PRIMARY_COMPARE_VALUE    (pri),
      .SECONDARY_COMPARE_VALUE  (sec),
      .SYNC_SOURCES             (sync_src),
      .COMPARE_TIMEBASE_COUNTER (cnt),
      .PRIMARY_MATCH            (pmatch),
      .SECONDARY_MATCH          (smatch),
      .CASCADED                 (casc)
   );

   // Free-running clock
   always #4 clk = ~clk;

   // Cut a hang short; tests need about 66k cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // Compare and count, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Wait n edges, then step off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Short reset with ticks, control words and sync sources idle
   task automatic do_reset();
      @(posedge clk) rst <= 1'b1;
      tick <= '0;
      ctrl <= '0;
      sync_src <= '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
   endtask

   // Free run, tick gating, both compare values
   task automatic test_free();
      do_reset();
      chk(cnt, 32'h0000_0000);
      @(posedge clk) pri <= {16'h0000, 16'h000B};
      sec <= {16'h0001, 16'h000B};
      @(posedge clk) tick <= 2'b01;
      cyc(10);
      chk(cnt, 32'h0000_000A);
      chk(pmatch, 32'h0000_0002);
      @(posedge clk) tick <= 2'b00;
      cyc(3);
      chk(cnt, 32'h0000_000B);
      chk({pmatch, smatch}, 32'h0000_000D);
      $display("test free_run done");
   endtask

   // Sync mode: runs at once, own source clears, other source ignored
   task automatic test_sync();
      do_reset();
      @(posedge clk) ctrl <= {16'h0000, 16'h0003};
      tick <= 2'b01;
      cyc(5);
      chk(cnt[0], 32'h0000_0005);
      @(posedge clk) sync_src <= 32'h0000_0010;
      @(posedge clk) sync_src <= 32'h0000_0000;
      #1 chk(cnt[0], 32'h0000_0007);
      @(posedge clk) sync_src <= 32'h0000_0008;
      @(posedge clk) sync_src <= 32'h0000_0000;
      #1 chk(cnt[0], 32'h0000_0000);
      $display("test sync_mode done");
   endtask

   // Trigger mode: held until the selected source fires
   task automatic test_trig();
      do_reset();
      @(posedge clk) ctrl <= {16'h0000, 16'h0082};
      tick <= 2'b01;
      cyc(6);
      chk(cnt[0], 32'h0000_0000);
      @(posedge clk) sync_src <= 32'h0000_0004;
      @(posedge clk) sync_src <= 32'h0000_0000;
      #1 chk(cnt[0], 32'h0000_0000);
      cyc(4);
      chk(cnt[0], 32'h0000_0004);
      $display("test trigger_mode done");
   endtask

   // Cascade needs both enables; low wrap carries into high half
   task automatic test_casc();
      do_reset();
      @(posedge clk) ctrl <= {16'h0000, 16'h0100};
      #1 chk(casc, 32'h0000_0000);
      @(posedge clk) ctrl <= {16'h0100, 16'h0100};
      tick <= 2'b01;
      pri <= {16'h0001, 16'h0000};
      sec <= {16'h0000, 16'hFFFF};
      #1 chk(casc, 32'h0000_0003);
      cyc(65535);
      chk(cnt, 32'h0000_FFFF);
      chk({pmatch, smatch}, 32'h0000_0000);
      cyc(1);
      chk(cnt, 32'h0001_0000);
      chk({pmatch, smatch}, 32'h0000_0003);
      cyc(1);
      chk({pmatch, smatch}, 32'h0000_000C);
      $display("test cascade done");
   endtask

   // Counts, then verdict
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      test_free();
      test_sync();
      test_trig();
      test_casc();
      report_and_stop();
   end
endmodule // tb_top
